// ### hdl/cdc_cfg.svh
// address map, reset values and timing counts of the comparator control block
`ifndef CDC_CFG_SVH
`define CDC_CFG_SVH
`define CDC_ADDR_W 4
`define CDC_DATA_W 8
`define CDC_A_CTRL_BASE 4'h0
`define CDC_A_CTRL_STRIDE 4'h2
`define CDC_A_MIRROR 4'h8
`define CDC_A_FLAGS 4'h9
`define CDC_A_ASEL 4'ha
`define CDC_A_PORT 4'hb
`define CDC_CTRL0_RST 8'h04
`define CDC_CTRL0_WMASK 8'h9f
`define CDC_CTRL1_RST 8'h00
`define CDC_ASEL_RST 8'hff
`define CDC_CLK_NS 20
`define CDC_ZLF_NS 20
`define CDC_ZLF_CYC_RAW (`CDC_ZLF_NS / `CDC_CLK_NS)
`define CDC_ZLF_CYC ((`CDC_ZLF_CYC_RAW < 1) ? 1 : `CDC_ZLF_CYC_RAW)
`define CDC_INSTR_CLKS 4
`define CDC_NUM_CMP 2
`endif

// ### hdl/cdc_pkg.sv
// types shared by the comparator control block
`default_nettype none
package cdc_pkg;
	typedef enum logic [2:0] {
		CDC_POS_PIN0  = 3'h0,
		CDC_POS_PIN1  = 3'h1,
		CDC_POS_FLT_A = 3'h2,
		CDC_POS_FLT_B = 3'h3,
		CDC_POS_DAC_B = 3'h4,
		CDC_POS_DAC_A = 3'h5,
		CDC_POS_REF2  = 3'h6,
		CDC_POS_GND   = 3'h7
	} cdc_pos_sel_t;
	typedef enum logic [2:0] {
		CDC_NEG_PIN0  = 3'h0,
		CDC_NEG_PIN1  = 3'h1,
		CDC_NEG_PIN2  = 3'h2,
		CDC_NEG_PIN3  = 3'h3,
		CDC_NEG_FLT_A = 3'h4,
		CDC_NEG_FLT_B = 3'h5,
		CDC_NEG_REF2  = 3'h6,
		CDC_NEG_GND   = 3'h7
	} cdc_neg_sel_t;
	typedef struct packed {
		logic comparator_enable_bit;
		logic comparator_result_bit;
		logic unused_bit;
		logic output_invert_bit;
		logic glitch_filter_enable;
		logic speed_power_select;
		logic hysteresis_enable;
		logic timer_sync_enable;
	} cdc_ctrl0_t;
	typedef struct packed {
		logic         rising_edge_irq_enable;
		logic         falling_edge_irq_enable;
		cdc_pos_sel_t positive_input_select;
		cdc_neg_sel_t negative_input_select;
	} cdc_ctrl1_t;
	typedef struct packed {
		logic         inputs_connected;
		logic         comparator_enable_bit;
		logic         speed_power_select;
		logic         hysteresis_enable;
		cdc_pos_sel_t positive_input_select;
		cdc_neg_sel_t negative_input_select;
	} cdc_analog_ctl_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cdc_bus_req_t;
endpackage
`default_nettype wire

// ### hdl/cdc_comparator_ctrl.sv
// digital control around the analog comparators: registers, filter, sync, edge flags
// Overview of operation
// - in sync mode sample the result on the divided timer clock falling edge
// - capture on falling timer edges because the timer counts on rising ones
// - rising and falling detectors set the shared flag when their enable is one
// - only software clears the flag; an edge during the clear keeps it set
// - toggling polarity or enable changes the output even while disabled
// - a cleared enable disconnects all comparator inputs whatever the selects say
// - with the filter on, a transition cannot reverse for 20 ns
// - port reads return zero for every pin set as analog input
// - control 0 bit 7 enables the comparator, resets to zero
// - control 0 bit 6 reads the result after polarity
// - control 0 bit 4 inverts the output; bit 5 reads zero
// - control 0 bit 3 routes the output through the glitch filter
// - control 0 bit 2 selects fast normal power, resets to one
// - control 0 bit 0 makes the timer and pin output follow timer falling edges
// - control 1 bits 7 and 6 enable flag setting on rising and falling edges
// - control 1 bits 5 to 3 pick the positive input source
// - control 1 bits 2 to 0 pick the negative input source
// - the software-visible result is re-latched once per instruction cycle
// - a read-only mirror holds comparator one at bit 0, two at bit 1
`include "cdc_cfg.svh"
`default_nettype none
module cdc_comparator_ctrl
	import cdc_pkg::*;
#(
	parameter int NUM_CMP     = `CDC_NUM_CMP,
	parameter int INSTR_CLKS  = `CDC_INSTR_CLKS,
	parameter int ZLF_CYC     = `CDC_ZLF_CYC
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	input  wire cdc_bus_req_t                  bus_req,
	output var  logic [7:0]                    rd_data,
	input  wire logic [NUM_CMP-1:0]            cmp_raw,
	input  wire logic                          tmr_clk_div,
	input  wire logic [7:0]                    port_pins,
	output var  cdc_analog_ctl_t [NUM_CMP-1:0] ana_ctl,
	output var  logic [NUM_CMP-1:0]            cmp_out,
	output var  logic [NUM_CMP-1:0]            comparator_irq_flag
);

	// the mirror and the address map only have room for two comparators
	if (NUM_CMP < 1 || NUM_CMP > 2) begin : g_chk_num
		$error("NUM_CMP must be 1 or 2");
	end
	// a single-clock instruction cycle would let edge pulses run together
	if (INSTR_CLKS < 2 || INSTR_CLKS > 255) begin : g_chk_instr
		$error("INSTR_CLKS must be 2 to 255");
	end
	if (ZLF_CYC < 1 || ZLF_CYC > 255) begin : g_chk_zlf
		$error("ZLF_CYC must be 1 to 255");
	end

	localparam logic [7:0] INSTR_LAST = 8'(INSTR_CLKS - 1);
	localparam logic [7:0] ZLF_LOAD   = 8'(ZLF_CYC);

	cdc_ctrl0_t         comparator_control_0 [NUM_CMP];
	cdc_ctrl1_t         comparator_control_1 [NUM_CMP];
	logic [7:0]         analog_select_register;
	logic [7:0]         instr_cnt;
	logic               tick;
	logic               tick_ce;
	logic [NUM_CMP-1:0] next_pol;
	logic [NUM_CMP-1:0] filt;
	logic [7:0]         hold_cnt [NUM_CMP];
	logic [NUM_CMP-1:0] result;
	logic [NUM_CMP-1:0] prev_result;
	logic [NUM_CMP-1:0] edge_set;
	logic [NUM_CMP-1:0] clr;
	logic               tclk_q;
	logic               tclk_fall;
	logic [NUM_CMP-1:0] sync_q;
	logic [7:0]         port_view;
	logic [7:0]         next_rd;

	function automatic logic [3:0] ctrl_addr(input int idx, input logic sel);
		ctrl_addr = 4'(`CDC_A_CTRL_BASE + `CDC_A_CTRL_STRIDE * idx) + {3'h0, sel};
	endfunction

	function automatic logic wr_hit(input cdc_bus_req_t req, input logic [3:0] a);
		wr_hit = req.wr && (req.addr == a);
	endfunction

	// configuration registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				comparator_control_0[i] <= cdc_ctrl0_t'(`CDC_CTRL0_RST);
				comparator_control_1[i] <= cdc_ctrl1_t'(`CDC_CTRL1_RST);
			end
			analog_select_register <= `CDC_ASEL_RST;
		end else if (ce) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				// result and bit 5 are never stored: they read from logic or as zero
				if (wr_hit(bus_req, ctrl_addr(i, 1'b0))) begin
					comparator_control_0[i] <=
						cdc_ctrl0_t'(bus_req.wdata & `CDC_CTRL0_WMASK);
				end
				if (wr_hit(bus_req, ctrl_addr(i, 1'b1))) begin
					comparator_control_1[i] <= cdc_ctrl1_t'(bus_req.wdata);
				end
			end
			if (wr_hit(bus_req, `CDC_A_ASEL)) begin
				analog_select_register <= bus_req.wdata;
			end
		end
	end

	// drive toward the analog core
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ana_ctl <= '0;
		end else if (ce) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				ana_ctl[i].inputs_connected <=
					comparator_control_0[i].comparator_enable_bit;
				ana_ctl[i].comparator_enable_bit <=
					comparator_control_0[i].comparator_enable_bit;
				ana_ctl[i].speed_power_select <=
					comparator_control_0[i].speed_power_select;
				ana_ctl[i].hysteresis_enable <=
					comparator_control_0[i].hysteresis_enable;
				ana_ctl[i].positive_input_select <=
					comparator_control_1[i].positive_input_select;
				ana_ctl[i].negative_input_select <=
					comparator_control_1[i].negative_input_select;
			end
		end
	end

	// a disabled core reads low, so enable and polarity still move the output
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			next_pol[i] = (cmp_raw[i] & comparator_control_0[i].comparator_enable_bit)
				^ comparator_control_0[i].output_invert_bit;
		end
	end

	// glitch filter: zero latency on the first change, then reversal is held off
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			filt <= '0;
			for (int i = 0; i < NUM_CMP; i++) begin
				hold_cnt[i] <= 8'h00;
			end
		end else if (ce) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (comparator_control_0[i].glitch_filter_enable && hold_cnt[i] != 8'h00) begin
					hold_cnt[i] <= hold_cnt[i] - 8'h01;
				end else begin
					filt[i] <= next_pol[i];
					hold_cnt[i] <= (next_pol[i] != filt[i]) ? ZLF_LOAD : 8'h00;
				end
			end
		end
	end

	// instruction cycle timebase
	assign tick = (instr_cnt == INSTR_LAST);
	assign tick_ce = tick & ce;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			instr_cnt <= 8'h00;
		end else if (ce) begin
			instr_cnt <= tick ? 8'h00 : instr_cnt + 8'h01;
		end
	end

	// latched result and edge detectors
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result <= '0;
			prev_result <= '0;
			edge_set <= '0;
		end else if (ce) begin
			if (tick) begin
				result <= filt;
			end
			prev_result <= result;
			for (int i = 0; i < NUM_CMP; i++) begin
				edge_set[i] <=
					(result[i] & ~prev_result[i] &
					 comparator_control_1[i].rising_edge_irq_enable) |
					(~result[i] & prev_result[i] &
					 comparator_control_1[i].falling_edge_irq_enable);
			end
		end
	end

	// flags clear by writing one; a simultaneous edge wins
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			clr[i] = wr_hit(bus_req, `CDC_A_FLAGS) && bus_req.wdata[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			comparator_irq_flag <= '0;
		end else if (ce) begin
			comparator_irq_flag <= edge_set | (comparator_irq_flag & ~clr);
		end
	end

	// timer clock is sampled as a plain input; the falling edge is seen on the first clock that samples it low
	assign tclk_fall = tclk_q & ~tmr_clk_div;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tclk_q <= 1'b0;
			sync_q <= '0;
			cmp_out <= '0;
		end else if (ce) begin
			tclk_q <= tmr_clk_div;
			if (tclk_fall) begin
				sync_q <= filt;
			end
			for (int i = 0; i < NUM_CMP; i++) begin
				// the asynchronous path still costs one flop: outputs are registered
				cmp_out[i] <= comparator_control_0[i].timer_sync_enable ?
					sync_q[i] : filt[i];
			end
		end
	end

	// register read port
	assign port_view = port_pins & ~analog_select_register;

	always_comb begin
		next_rd = 8'h00;
		if (bus_req.addr == `CDC_A_MIRROR) begin
			next_rd = 8'(result);
		end else if (bus_req.addr == `CDC_A_FLAGS) begin
			next_rd = 8'(comparator_irq_flag);
		end else if (bus_req.addr == `CDC_A_ASEL) begin
			next_rd = analog_select_register;
		end else if (bus_req.addr == `CDC_A_PORT) begin
			next_rd = port_view;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (bus_req.addr == ctrl_addr(i, 1'b0)) begin
					next_rd = comparator_control_0[i];
					next_rd[6] = result[i];
				end else if (bus_req.addr == ctrl_addr(i, 1'b1)) begin
					next_rd = comparator_control_1[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_data <= bus_req.rd ? next_rd : 8'h00;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	for (genvar g = 0; g < NUM_CMP; g++) begin : g_chk
		flag_set_a: assert property (ce && edge_set[g] |=> comparator_irq_flag[g])
			else $error("edge did not set flag");
		flag_clear_a: assert property (
			ce && clr[g] && !edge_set[g] |=> !comparator_irq_flag[g])
			else $error("flag not cleared");
		inputs_off_a: assert property (
			ce && !comparator_control_0[g].comparator_enable_bit
			|=> !ana_ctl[g].inputs_connected)
			else $error("inputs connected while disabled");
		zlf_hold_a: assert property (
			ce && !bus_req.wr && comparator_control_0[g].glitch_filter_enable
			&& $changed(filt[g]) |=> $stable(filt[g]))
			else $error("filter let output reverse");
		polarity_path_a: assert property (
			ce && !bus_req.wr && !comparator_control_0[g].glitch_filter_enable
			|=> filt[g] == $past(next_pol[g]))
			else $error("unfiltered output wrong");
		sync_latch_a: assert property (ce && !tclk_fall |=> $stable(sync_q[g]))
			else $error("sync latch moved off falling edge");
		result_tick_a: assert property ($changed(result[g]) |-> $past(tick_ce))
			else $error("result latched off instruction cycle");
		edge_pulse_a: assert property (ce && edge_set[g] |=> !edge_set[g])
			else $error("edge pulse longer than one cycle");
		// ce is taken on the load edge, so a frozen block never trips these
		flag_hold_a: assert property (
			ce && comparator_irq_flag[g] && !clr[g]
			|=> comparator_irq_flag[g])
			else $error("flag dropped without a clear");
		flag_quiet_a: assert property (
			ce && !comparator_irq_flag[g] && !edge_set[g]
			|=> !comparator_irq_flag[g])
			else $error("flag set without an edge");
		edge_rise_a: assert property (
			ce && result[g] && !prev_result[g]
			&& comparator_control_1[g].rising_edge_irq_enable |=> edge_set[g])
			else $error("rising edge missed");
		edge_fall_a: assert property (
			ce && !result[g] && prev_result[g]
			&& comparator_control_1[g].falling_edge_irq_enable |=> edge_set[g])
			else $error("falling edge missed");
		edge_quiet_a: assert property (
			ce && result[g] == prev_result[g]
			|=> !edge_set[g])
			else $error("edge pulse without a change");
		disabled_pol_a: assert property (
			!comparator_control_0[g].comparator_enable_bit
			|-> next_pol[g] == comparator_control_0[g].output_invert_bit)
			else $error("disabled output not the polarity bit");
		zlf_count_a: assert property (
			hold_cnt[g] <= ZLF_LOAD)
			else $error("hold-off counter out of range");
		async_out_a: assert property (
			ce && !comparator_control_0[g].timer_sync_enable
			|=> cmp_out[g] == $past(filt[g]))
			else $error("asynchronous output wrong");
		sync_out_a: assert property (
			ce && comparator_control_0[g].timer_sync_enable
			|=> cmp_out[g] == $past(sync_q[g]))
			else $error("synchronous output wrong");
		sync_load_a: assert property (
			ce && tclk_fall
			|=> sync_q[g] == $past(filt[g]))
			else $error("sync latch missed falling edge");
		power_drive_a: assert property (
			ce |=> ana_ctl[g].speed_power_select
			== $past(comparator_control_0[g].speed_power_select))
			else $error("speed select not driven");
		hyst_drive_a: assert property (
			ce |=> ana_ctl[g].hysteresis_enable
			== $past(comparator_control_0[g].hysteresis_enable))
			else $error("hysteresis not driven");
		pos_drive_a: assert property (
			ce |=> ana_ctl[g].positive_input_select
			== $past(comparator_control_1[g].positive_input_select))
			else $error("positive select not driven");
		neg_drive_a: assert property (
			ce |=> ana_ctl[g].negative_input_select
			== $past(comparator_control_1[g].negative_input_select))
			else $error("negative select not driven");
		ctrl0_read_a: assert property (
			ce && bus_req.rd && bus_req.addr == ctrl_addr(g, 1'b0)
			|=> rd_data[6] == $past(result[g]) && !rd_data[5])
			else $error("control 0 status bits wrong");
		flag_rise_c: cover property (ce && edge_set[g] && result[g]);
		flag_race_c: cover property (ce && edge_set[g] && clr[g]);
		zlf_block_c: cover property (ce && hold_cnt[g] != 8'h00
			&& next_pol[g] != filt[g] && comparator_control_0[g].glitch_filter_enable);
	end

	port_read_a: assert property (
		ce && bus_req.rd && bus_req.addr == `CDC_A_PORT
		|=> rd_data == $past(port_view)
		&& (rd_data & $past(analog_select_register)) == 8'h00)
		else $error("analog pin read not zero");
	rd_idle_a: assert property (
		ce && !bus_req.rd |=> rd_data == 8'h00)
		else $error("read data outside a read");
	mirror_read_a: assert property (
		ce && bus_req.rd && bus_req.addr == `CDC_A_MIRROR
		|=> rd_data == 8'($past(result)))
		else $error("mirror read wrong");
	instr_wrap_a: assert property (
		instr_cnt <= INSTR_LAST)
		else $error("instruction counter out of range");
	sync_out_c: cover property (ce && tclk_fall && sync_q != filt);

endmodule
`default_nettype wire

// ### verification/test_comparator_digital_control.sv
// self-checking bench for the comparator control block
`include "cdc_cfg.svh"
`default_nettype none
module test_comparator_digital_control
	import cdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ZLF = `CDC_ZLF_CYC;
	localparam logic [3:0] A_C0 = `CDC_A_CTRL_BASE;
	localparam logic [3:0] A_C1 = `CDC_A_CTRL_BASE + 4'h1;
	localparam logic [3:0] A_C2 = `CDC_A_CTRL_BASE + `CDC_A_CTRL_STRIDE;
	localparam logic [3:0] A_MIR = `CDC_A_MIRROR;
	localparam logic [3:0] A_FLG = `CDC_A_FLAGS;
	logic                    core_clk;
	logic                    rst_n;
	logic                    ce;
	cdc_bus_req_t            bus_req;
	logic [7:0]              rd_data;
	logic [1:0]              cmp_raw;
	logic                    tmr_clk_div;
	logic [7:0]              port_pins;
	cdc_analog_ctl_t [1:0]   ana_ctl;
	logic [1:0]              cmp_out;
	logic [1:0]              comparator_irq_flag;
	int                      num_errors;
	int                      n_tests;
	logic [31:0]             r;
	logic [7:0]              w;
	logic [7:0]              v;
	logic [7:0]              n;

	cdc_comparator_ctrl #(.NUM_CMP(2), .INSTR_CLKS(`CDC_INSTR_CLKS), .ZLF_CYC(ZLF)) dut (
		.core_clk            (core_clk),
		.rst_n               (rst_n),
		.ce                  (ce),
		.bus_req             (bus_req),
		.rd_data             (rd_data),
		.cmp_raw             (cmp_raw),
		.tmr_clk_div         (tmr_clk_div),
		.port_pins           (port_pins),
		.ana_ctl             (ana_ctl),
		.cmp_out             (cmp_out),
		.comparator_irq_flag (comparator_irq_flag)
	);

	always #10 core_clk = ~core_clk;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk(what, rd_data, exp);
	endtask

	// bits 6 and 5 are not writable; bit 6 is the latched result
	function automatic logic [7:0] exp_c0(input logic [7:0] wv, input logic res);
		return (wv & `CDC_CTRL0_WMASK) | {1'b0, res, 6'h00};
	endfunction

	task automatic pulse_width(input logic [7:0] c0, output logic [7:0] cnt);
		wr(A_C0, c0);
		cyc(8);
		cnt = 8'h00;
		@(posedge core_clk) cmp_raw[0] <= 1'b1;
		@(posedge core_clk) cmp_raw[0] <= 1'b0;
		repeat (8) begin
			cyc(1);
			cnt = cnt + {7'h00, cmp_out[0]};
		end
	endtask

	// generous bound: the whole sequence needs about 620 cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		complete_run();
	end

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		bus_req = '0;
		cmp_raw = 2'b00;
		tmr_clk_div = 1'b1;
		port_pins = 8'h00;
		void'($urandom(32'h6d0b));
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		rchk("ctrl0 reset", A_C0, `CDC_CTRL0_RST);
		rchk("ctrl1 reset", A_C1, 8'h00);
		rchk("mirror reset", A_MIR, 8'h00);
		rchk("unmapped", 4'hc, 8'h00);
		chk("inputs off", {7'h00, ana_ctl[0].inputs_connected}, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			w = r[15:8];
			v = {r[7:6], 3'(i), 3'(7 - i)};
			wr(A_C0, w);
			wr(A_C1, v);
			cyc(8);
			rchk("ctrl1", A_C1, v);
			rchk("ctrl0", A_C0, exp_c0(w, w[4]));
			chk("selects", {2'b00, ana_ctl[0].positive_input_select,
				ana_ctl[0].negative_input_select}, {2'b00, v[5:0]});
			chk("analog", {4'h0, ana_ctl[0].inputs_connected, ana_ctl[0].comparator_enable_bit,
				ana_ctl[0].speed_power_select, ana_ctl[0].hysteresis_enable},
				{4'h0, w[7], w[7], w[2], w[1]});
		end
		$display("test config done");
		wr(A_C0, 8'h84);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			@(posedge core_clk) cmp_raw[1] <= r[0];
			w = {1'b1, 1'b0, r[2], r[1], 4'h4};
			wr(A_C2, w);
			cyc(8);
			rchk("ctrl0 two", A_C2, exp_c0(w, r[0] ^ r[1]));
			rchk("mirror", A_MIR, {6'h00, r[0] ^ r[1], 1'b0});
			chk("cmp two", {6'h00, ana_ctl[1].inputs_connected, cmp_out[1]},
				{6'h00, 1'b1, r[0] ^ r[1]});
		end
		$display("test polarity done");
		wr(A_FLG, 8'h03);
		for (int m = 0; m < 4; m++) begin
			wr(A_C1, {2'(m), 6'h00});
			@(posedge core_clk) cmp_raw[0] <= 1'b1;
			cyc(12);
			rchk("flag rise", A_FLG, {7'h00, m[1]});
			wr(A_FLG, 8'h01);
			@(posedge core_clk) cmp_raw[0] <= 1'b0;
			cyc(12);
			rchk("flag fall", A_FLG, {7'h00, m[0]});
			wr(A_FLG, 8'h01);
			cyc(1);
			chk("flag clear", {7'h00, comparator_irq_flag[0]}, 8'h00);
		end
		$display("test edges done");
		wr(A_C0, 8'h04);
		wr(A_C1, 8'h80);
		@(posedge core_clk) cmp_raw[0] <= 1'b1;
		cyc(12);
		wr(A_FLG, 8'h01);
		wr(A_C0, 8'h14);
		cyc(12);
		rchk("polarity flag", A_FLG, 8'h01);
		rchk("disabled ctrl0", A_C0, 8'h54);
		wr(A_C0, 8'h04);
		cyc(12);
		wr(A_FLG, 8'h01);
		wr(A_C0, 8'h84);
		cyc(12);
		rchk("enable flag", A_FLG, 8'h01);
		$display("test disabled done");
		@(posedge core_clk) port_pins <= 8'hff;
		rchk("port analog", `CDC_A_PORT, 8'h00);
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			wr(`CDC_A_ASEL, r[7:0]);
			@(posedge core_clk) port_pins <= r[15:8];
			rchk("port", `CDC_A_PORT, r[15:8] & ~r[7:0]);
		end
		$display("test port done");
		wr(A_C1, 8'h00);
		@(posedge core_clk) cmp_raw[0] <= 1'b0;
		wr(A_C0, 8'h85);
		cyc(8);
		@(posedge core_clk) cmp_raw[0] <= 1'b1;
		cyc(8);
		chk("sync hold", {7'h00, cmp_out[0]}, 8'h00);
		@(posedge core_clk) tmr_clk_div <= 1'b0;
		cyc(4);
		chk("sync fall", {7'h00, cmp_out[0]}, 8'h01);
		@(posedge core_clk) tmr_clk_div <= 1'b1;
		cmp_raw[0] <= 1'b0;
		cyc(8);
		chk("sync rise", {7'h00, cmp_out[0]}, 8'h01);
		@(posedge core_clk) tmr_clk_div <= 1'b0;
		cyc(4);
		chk("sync fall2", {7'h00, cmp_out[0]}, 8'h00);
		wr(A_C0, 8'h84);
		@(posedge core_clk) cmp_raw[0] <= 1'b1;
		cyc(4);
		chk("async", {7'h00, cmp_out[0]}, 8'h01);
		@(posedge core_clk) cmp_raw[0] <= 1'b0;
		cyc(4);
		// a low clock enable must freeze the output path while the input moves
		@(posedge core_clk) ce <= 1'b0;
		cmp_raw[0] <= 1'b1;
		cyc(6);
		chk("ce freeze", {7'h00, cmp_out[0]}, 8'h00);
		@(posedge core_clk) ce <= 1'b1;
		cyc(4);
		chk("ce resume", {7'h00, cmp_out[0]}, 8'h01);
		@(posedge core_clk) cmp_raw[0] <= 1'b0;
		$display("test sync done");
		// a one-cycle glitch passes unfiltered and is stretched when filtered
		pulse_width(8'h84, n);
		chk("unfiltered", n, 8'h01);
		pulse_width(8'h8c, n);
		chk("filtered", n, 8'(1 + ZLF));
		$display("test filter done");
		complete_run();
	end
endmodule
`default_nettype wire
